// ### shared/sgan_pkg.sv
// Package for the SGMII negotiation unit: register map, field positions, timer lengths in microseconds, states.
// Assumes one 200 MHz core clock and a simple word-wide management port.
package sgan_pkg;
   // ==========================================================
   // Register map.
   localparam logic [4:0] SGAN_REG_CONTROL = 5'h00; // Control, bit 9 restarts.
   localparam logic [4:0] SGAN_REG_STATUS = 5'h01; // Status, bit 5 complete.
   localparam logic [4:0] SGAN_REG_ADVERT = 5'h04; // Local ability word.
   localparam logic [4:0] SGAN_REG_PARTNER = 5'h05; // Partner ability word.
   localparam logic [4:0] SGAN_REG_IRQ_CTRL = 5'h10; // Interrupt control.
   localparam int SGAN_BIT_RESTART = 9;
   localparam int SGAN_BIT_AN_EN = 12;
   localparam int SGAN_BIT_DONE = 5;
   localparam int SGAN_BIT_IRQ_EN = 0;
   localparam int SGAN_BIT_IRQ_STAT = 1;
   localparam logic [15:0] SGAN_CONTROL_RST = 16'h1000;
   localparam logic [15:0] SGAN_ADVERT_RST = 16'h0001;
   // Partner word fields: speed [11:10], duplex 12, acknowledge 14.
   localparam int SGAN_SPD_LO = 10;
   localparam int SGAN_DUP_BIT = 12;
   localparam int SGAN_ACK_BIT = 14;
   // ==========================================================
   // Timer and receive constants.
   localparam int SGAN_CLK_MHZ = 200;
   localparam int SGAN_SGMII_TIMER_US = 1600; // 1.6 ms.
   localparam int SGAN_BASEX_TIMER_US = 10000; // 10 ms.
   localparam int SGAN_MATCH_NEEDED = 3;
   localparam logic [2:0] SGAN_BUFSTAT_ERR = 3'h4; // Bit 2 flags under/overflow.
   // ==========================================================
   // Negotiation states.
   typedef enum logic [5:0] {
      SGAN_ST_IDLE = 6'b000001,
      SGAN_ST_RESTART = 6'b000010,
      SGAN_ST_ABILITY = 6'b000100,
      SGAN_ST_ACK = 6'b001000,
      SGAN_ST_WAIT = 6'b010000,
      SGAN_ST_DONE = 6'b100000
   } sgan_state_t;
   // Management request carried as one bundle.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] addr;
      logic [15:0] wdata;
   } sgan_mgmt_req_t;
endpackage

// ### hw/sgan_core.sv
// SGMII negotiation unit: ability exchange, link timer, status and completion interrupt.
// Assumes the receive path delivers decoded config words with a valid strobe.
//
// Operation
// - SGMII link timer is 1.6 ms.
// - Exchange speed and duplex word; store partner's.
// - Partner speed and duplex on status bus.
// - Negotiate only across the serial link.
// - PHY mode forwards MDIO-learned abilities over SGMII.
// - Interrupt controlled only by register 16.
// - Disabled interrupt output stays low.
// - Interrupt high on completion until cleared.
// - Idle insertion or deletion is harmless.
// - Tolerate fragments from second correction sequence.
// - Nonzero correction count drops the word when enabled.
// - Buffer errors recovered; negotiation still completes.
// - Restart on reset, sync loss, software, and partner (all-zero word) once done.
// - Completion bit at status 1.5.
`timescale 1ns/100ps
module sgan_core
   import sgan_pkg::*;
#(
   parameter int SGMII_TIMER_CYC = SGAN_SGMII_TIMER_US * SGAN_CLK_MHZ,
   parameter int BASEX_TIMER_CYC = SGAN_BASEX_TIMER_US * SGAN_CLK_MHZ
) (
   // Clock, reset, enable.
   input wire logic mclk,
   input wire logic rst,
   input wire logic clk_en,
   // Configuration.
   input wire logic sgmii_mode,
   input wire logic phy_mode,
   input wire logic second_correction_seq_enable,
   input wire logic [15:0] phy_mdio_ability,
   // Receive side.
   input wire logic sync_ok,
   input wire logic rx_cfg_valid,
   input wire logic [15:0] rx_cfg_word,
   input wire logic rx_idle,
   input wire logic [2:0] rx_clk_cor_cnt,
   input wire logic [2:0] rx_buf_status,
   // Management port.
   input wire sgan_mgmt_req_t mgmt_req,
   output logic [15:0] mgmt_rdata,
   // Transmit and status.
   output logic tx_cfg_send,
   output logic [15:0] tx_cfg_word,
   output logic [2:0] status_speed_duplex,
   output logic negotiation_done_irq
);
   // ==========================================================
   // Registers.
   sgan_state_t st_q, st_d;
   logic [31:0] tmr_q, tmr_d; // Link timer in core cycles.
   logic [15:0] ctrl_q, ctrl_d;
   logic [15:0] adv_q, adv_d;
   logic [15:0] lp_q, lp_d; // Partner ability word.
   logic [15:0] cand_q, cand_d; // Word being matched.
   logic [1:0] match_q, match_d;
   logic done_q, done_d;
   logic irq_en_q, irq_en_d;
   logic irq_st_q, irq_st_d;
   logic sel_sgmii_q, sel_sgmii_d; // Standard latched at start.
   logic sync_q, sync_d;
   logic [15:0] rdata_q, rdata_d;
   logic [2:0] stat_q, stat_d;
   logic irq_q, irq_d;
   logic [31:0] tmr_end;
   logic rx_good;
   logic restart_req;
   logic wr_ctrl;
   logic done_evt;

   // The standard is latched when a cycle starts so a mid-cycle switch finishes as begun.
   assign tmr_end = sel_sgmii_q ? 32'(SGMII_TIMER_CYC - 1) : 32'(BASEX_TIMER_CYC - 1);
   // A word received alongside a buffer error or correction fragment is dropped, not
   // treated as a mismatch, so the matcher keeps its progress.
   assign rx_good = rx_cfg_valid && (rx_buf_status != SGAN_BUFSTAT_ERR)
      && !(second_correction_seq_enable && (rx_clk_cor_cnt != 3'h0));
   assign wr_ctrl = mgmt_req.wr && (mgmt_req.addr == SGAN_REG_CONTROL);
   assign restart_req = (wr_ctrl && mgmt_req.wdata[SGAN_BIT_RESTART])
      || (sync_q && !sync_ok);

   // ==========================================================
   // Next-state logic for negotiation.
   always_comb begin
      st_d = st_q;
      tmr_d = tmr_q;
      cand_d = cand_q;
      match_d = match_q;
      lp_d = lp_q;
      done_d = done_q;
      sel_sgmii_d = sel_sgmii_q;
      sync_d = sync_ok;
      done_evt = 1'b0;
      if (rx_good && (rx_cfg_word == cand_q)) begin
         if (match_q != 2'(SGAN_MATCH_NEEDED)) begin
            match_d = match_q + 2'h1;
         end
      end else if (rx_good) begin
         cand_d = rx_cfg_word;
         match_d = 2'h1;
      end
      // Idles are ignored by the matcher, so inserted or removed /I2/ sets at most delay the step from ability to acknowledge.
      case (st_q)
         SGAN_ST_IDLE: begin
            if (ctrl_q[SGAN_BIT_AN_EN] && sync_ok) begin
               st_d = SGAN_ST_RESTART;
               tmr_d = 32'h0;
               sel_sgmii_d = sgmii_mode;
            end
         end
         SGAN_ST_RESTART: begin
            tmr_d = tmr_q + 32'h1;
            done_d = 1'b0;
            if (tmr_q == tmr_end) begin
               st_d = SGAN_ST_ABILITY;
               match_d = 2'h0;
            end
         end
         SGAN_ST_ABILITY: begin
            if (match_q == 2'(SGAN_MATCH_NEEDED) && !rx_idle) begin
               st_d = SGAN_ST_ACK;
               lp_d = cand_q;
            end
         end
         SGAN_ST_ACK: begin
            if (match_q == 2'(SGAN_MATCH_NEEDED) && cand_q[SGAN_ACK_BIT]) begin
               st_d = SGAN_ST_WAIT;
               tmr_d = 32'h0;
            end
         end
         SGAN_ST_WAIT: begin
            tmr_d = tmr_q + 32'h1;
            if (tmr_q == tmr_end) begin
               st_d = SGAN_ST_DONE;
               done_d = 1'b1;
               done_evt = 1'b1;
            end
         end
         SGAN_ST_DONE: begin
            // A fresh partner restart shows as a config word of all zero.
            if (rx_good && rx_cfg_word == 16'h0000) begin
               st_d = SGAN_ST_RESTART;
               tmr_d = 32'h0;
               sel_sgmii_d = sgmii_mode;
            end
         end
         default: begin
            st_d = SGAN_ST_IDLE;
         end
      endcase
      if (restart_req || !ctrl_q[SGAN_BIT_AN_EN]) begin
         st_d = ctrl_q[SGAN_BIT_AN_EN] ? SGAN_ST_RESTART : SGAN_ST_IDLE;
         tmr_d = 32'h0;
         done_d = 1'b0;
         sel_sgmii_d = sgmii_mode;
      end
   end

   // ==========================================================
   // Next-state logic for management registers and outputs.
   always_comb begin
      ctrl_d = ctrl_q;
      adv_d = adv_q;
      irq_en_d = irq_en_q;
      irq_st_d = irq_st_q;
      rdata_d = rdata_q;
      if (wr_ctrl) begin
         ctrl_d = mgmt_req.wdata & ~(16'h0001 << SGAN_BIT_RESTART);
      end
      if (mgmt_req.wr && mgmt_req.addr == SGAN_REG_ADVERT) begin
         adv_d = mgmt_req.wdata;
      end
      // Only register 16 touches the interrupt; a write of zero clears the status.
      if (mgmt_req.wr && mgmt_req.addr == SGAN_REG_IRQ_CTRL) begin
         irq_en_d = mgmt_req.wdata[SGAN_BIT_IRQ_EN];
         if (!mgmt_req.wdata[SGAN_BIT_IRQ_STAT]) begin
            irq_st_d = 1'b0;
         end
      end
      // Completion in the clearing cycle wins, so no event is lost.
      if (done_evt && irq_en_d) begin
         irq_st_d = 1'b1;
      end
      if (!irq_en_d) begin
         irq_st_d = 1'b0;
      end
      if (mgmt_req.rd) begin
         case (mgmt_req.addr)
            SGAN_REG_CONTROL: rdata_d = ctrl_q;
            SGAN_REG_STATUS: rdata_d = 16'(done_q) << SGAN_BIT_DONE;
            SGAN_REG_ADVERT: rdata_d = adv_q;
            SGAN_REG_PARTNER: rdata_d = lp_q;
            SGAN_REG_IRQ_CTRL: rdata_d = {14'h0, irq_st_q, irq_en_q};
            default: rdata_d = 16'h0000;
         endcase
      end
      stat_d = {lp_q[SGAN_DUP_BIT], lp_q[SGAN_SPD_LO +: 2]};
      irq_d = irq_en_d && irq_st_d;
   end

   // ==========================================================
   // State registers; the clock enable freezes everything.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_q <= SGAN_ST_IDLE;
         tmr_q <= 32'h0;
         ctrl_q <= SGAN_CONTROL_RST;
         adv_q <= SGAN_ADVERT_RST;
         lp_q <= 16'h0000;
         cand_q <= 16'h0000;
         match_q <= 2'h0;
         done_q <= 1'b0;
         irq_en_q <= 1'b0;
         irq_st_q <= 1'b0;
         sel_sgmii_q <= 1'b0;
         sync_q <= 1'b0;
         rdata_q <= 16'h0000;
         stat_q <= 3'h0;
         irq_q <= 1'b0;
      end else if (clk_en) begin
         st_q <= st_d;
         tmr_q <= tmr_d;
         ctrl_q <= ctrl_d;
         adv_q <= adv_d;
         lp_q <= lp_d;
         cand_q <= cand_d;
         match_q <= match_d;
         done_q <= done_d;
         irq_en_q <= irq_en_d;
         irq_st_q <= irq_st_d;
         sel_sgmii_q <= sel_sgmii_d;
         sync_q <= sync_d;
         rdata_q <= rdata_d;
         stat_q <= stat_d;
         irq_q <= irq_d;
      end
   end

   // ==========================================================
   // Transmit word: the advertisement, or in PHY mode with SGMII latched the MDIO-learned medium result.
   // Only the serial exchange is driven here; copper negotiation lives in the PHY.
   logic [15:0] txw_q, txw_d;
   logic txs_q, txs_d;
   always_comb begin
      txs_d = (st_q != SGAN_ST_IDLE) && (st_q != SGAN_ST_DONE);
      txw_d = (st_q == SGAN_ST_RESTART) ? 16'h0000 :
         (((phy_mode && sel_sgmii_q) ? phy_mdio_ability : adv_q)
         | ((st_q == SGAN_ST_ACK || st_q == SGAN_ST_WAIT) ? (16'h0001 << SGAN_ACK_BIT)
         : 16'h0000));
   end
   // Transmit registers only; the clock enable freezes them with the rest.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         txw_q <= 16'h0000;
         txs_q <= 1'b0;
      end else if (clk_en) begin
         txs_q <= txs_d;
         txw_q <= txw_d;
      end
   end

   assign mgmt_rdata = rdata_q;
   assign tx_cfg_send = txs_q;
   assign tx_cfg_word = txw_q;
   assign status_speed_duplex = stat_q;
   assign negotiation_done_irq = irq_q;

   // ==========================================================
   // Checks.
   sequence s_wait_end;
      (st_q == SGAN_ST_WAIT) && (tmr_q == tmr_end) && clk_en && !restart_req
         && ctrl_q[SGAN_BIT_AN_EN];
   endsequence
   AST_DONE_SET: assert property (@(posedge mclk) disable iff (rst)
      s_wait_end |=> done_q) else $error("done bit not set after link timer");
   AST_IRQ_LOW: assert property (@(posedge mclk) disable iff (rst)
      !irq_en_q |-> !negotiation_done_irq) else $error("irq high while disabled");
   AST_IRQ_HOLD: assert property (@(posedge mclk) disable iff (rst)
      (irq_q && irq_en_q && !mgmt_req.wr && clk_en) |=> irq_q) else $error("irq dropped early");
   AST_LP_STORE: assert property (@(posedge mclk) disable iff (rst)
      (st_q == SGAN_ST_ABILITY && st_d == SGAN_ST_ACK && clk_en) |=> lp_q == $past(cand_q))
      else $error("partner word not stored");
   AST_STAT_BUS: assert property (@(posedge mclk) disable iff (rst)
      clk_en |=> status_speed_duplex == {$past(lp_q[SGAN_DUP_BIT]),
      $past(lp_q[SGAN_SPD_LO +: 2])}) else $error("status bus mismatch");
   AST_BUF_ERR: assert property (@(posedge mclk) disable iff (rst)
      (rx_buf_status == SGAN_BUFSTAT_ERR && st_q != SGAN_ST_RESTART && clk_en)
      |=> $stable(match_q))
      else $error("buffer error disturbed matcher");
   AST_COR_FRAG: assert property (@(posedge mclk) disable iff (rst)
      (second_correction_seq_enable && rx_clk_cor_cnt != 3'h0 && clk_en) |=> $stable(cand_q))
      else $error("correction fragment accepted");
   AST_RESTART: assert property (@(posedge mclk) disable iff (rst)
      (wr_ctrl && mgmt_req.wdata[SGAN_BIT_RESTART] && ctrl_q[SGAN_BIT_AN_EN] && clk_en)
      |=> st_q == SGAN_ST_RESTART && tmr_q == 32'h0) else $error("restart not taken");
endmodule

// ### dv/sgan_phy_model.sv
// Far-side SGMII partner: answers the unit's config words with its own ability word.
// Assumes the bench clock and reset; it changes its outputs on falling edges, or at once when reset rises.
`timescale 1ns/100ps
module sgan_phy_model (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst,
   // Words sent by the unit.
   input wire logic tx_cfg_send,
   input wire logic [15:0] tx_cfg_word,
   // Medium result that the partner already holds.
   input wire logic [15:0] ability,
   // Words sent to the unit.
   output logic rx_cfg_valid,
   output logic [15:0] rx_cfg_word
);
   // ==========================================================
   // Word sender.
   int sent; // Words sent since the unit began advertising.
   // The medium result is settled before the first word, so it never changes mid-exchange.
   always @(negedge mclk or posedge rst) begin
      if (rst) begin
         sent = 0;
         rx_cfg_valid = 1'b0;
         rx_cfg_word = 16'h0000;
      end else if (tx_cfg_send && tx_cfg_word != 16'h0000) begin
         rx_cfg_valid = 1'b1;
         rx_cfg_word = (sent < 4) ? ability : (ability | 16'h4000);
         sent = sent + 1;
      end else begin
         // A released line toggles, so a stale word can never pass for a fresh one.
         sent = 0;
         rx_cfg_valid = 1'b0;
         rx_cfg_word = ~rx_cfg_word;
      end
   end
endmodule

// ### dv/tb_sgan_core.sv
// Self-checking bench for the SGMII negotiation unit with a partner model.
// Assumes shortened link timers; inputs change on falling edges.
`timescale 1ns/100ps
module tb_sgan_core;
   import sgan_pkg::*;
   localparam int SG_CYC = 20; // Shortened SGMII timer.
   localparam int BX_CYC = 60; // Shortened 1000BASE-X timer.
   logic mclk, rst, sgmii_mode, phy_mode, corr_en, sync_ok, noisy, rx_valid, tx_send, irq;
   logic ok, irq_hi, ce;
   logic [15:0] mdio_ab, ab, rdata, tx_word, rx_word, got;
   logic [2:0] spd_dup;
   sgan_mgmt_req_t req;
   int fail_count, n_checks, cyc, n_sg, n_bx;
   sgan_core #(.SGMII_TIMER_CYC(SG_CYC), .BASEX_TIMER_CYC(BX_CYC)) dut_u (
      .mclk(mclk), .rst(rst), .clk_en(ce), .sgmii_mode(sgmii_mode), .phy_mode(phy_mode),
      .second_correction_seq_enable(corr_en), .phy_mdio_ability(mdio_ab), .sync_ok(sync_ok),
      .rx_cfg_valid(rx_valid), .rx_cfg_word(rx_word), .rx_idle(noisy && cyc % 5 == 0),
      .rx_clk_cor_cnt((noisy && cyc % 5 == 1) ? 3'h1 : 3'h0),
      .rx_buf_status((noisy && cyc % 5 == 3) ? SGAN_BUFSTAT_ERR : 3'h0),
      .mgmt_req(req), .mgmt_rdata(rdata), .tx_cfg_send(tx_send), .tx_cfg_word(tx_word),
      .status_speed_duplex(spd_dup), .negotiation_done_irq(irq));
   sgan_phy_model partner_u (.mclk(mclk), .rst(rst), .tx_cfg_send(tx_send),
      .tx_cfg_word(tx_word), .ability(ab), .rx_cfg_valid(rx_valid), .rx_cfg_word(rx_word));
   // ==========================================================
   // Clock, cycle count and hang guard.
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // The ceiling is far above the few hundred cycles the scenarios need.
   always @(negedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         wrap_up();
      end
   end
   // ==========================================================
   // Shared tasks.
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One-cycle management write.
   task automatic wr(logic [4:0] a, logic [15:0] d);
      @(negedge mclk) req = '{1'b1, 1'b0, a, d};
      @(negedge mclk) req = '0;
   endtask
   // Read data is registered, so it is taken two cycles after the request edge.
   task automatic rd(logic [4:0] a);
      @(negedge mclk) req = '{1'b0, 1'b1, a, 16'h0000};
      @(negedge mclk) req = '0;
      @(negedge mclk) got = rdata;
   endtask
   // Poll the completion bit, noting whether the interrupt ever went high.
   task automatic wait_done(output int n);
      int t0;
      t0 = cyc;
      ok = 1'b0;
      irq_hi = 1'b0;
      repeat (300) begin
         if (!ok) begin
            rd(SGAN_REG_STATUS);
            irq_hi |= irq;
            ok = got[SGAN_BIT_DONE];
         end
      end
      n = cyc - t0;
   endtask
   // Software restart; completion must drop at once.
   task automatic restart();
      wr(SGAN_REG_CONTROL, 16'h1200);
      rd(SGAN_REG_STATUS);
      check("done after restart", {15'h0000, got[SGAN_BIT_DONE]}, 16'h0000);
   endtask
   task automatic wrap_up();
      if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ==========================================================
   // Scenarios.
   task automatic t_reset();
      rd(SGAN_REG_CONTROL);
      check("control reset", got, SGAN_CONTROL_RST);
      rd(SGAN_REG_ADVERT);
      check("advert reset", got, SGAN_ADVERT_RST);
      rd(SGAN_REG_IRQ_CTRL);
      check("irq ctrl reset", got, 16'h0000);
      rd(5'h1F);
      check("unmapped read", got, 16'h0000);
   endtask
   // Negotiation from reset with the interrupt on, then a clear by software.
   task automatic t_irq_and_result();
      wr(SGAN_REG_IRQ_CTRL, 16'h0001);
      wait_done(n_sg);
      check("done set", {15'h0000, ok}, 16'h0001);
      check("irq raised", {15'h0000, irq}, 16'h0001);
      rd(SGAN_REG_PARTNER);
      check("partner word", got & 16'h1C00, ab & 16'h1C00);
      check("status bus", {13'h0000, spd_dup}, {13'h0000, ab[12], ab[11:10]});
      rd(SGAN_REG_ADVERT);
      check("irq holds", {15'h0000, irq}, 16'h0001);
      wr(SGAN_REG_IRQ_CTRL, 16'h0001);
      @(negedge mclk);
      check("irq cleared", {15'h0000, irq}, 16'h0000);
   endtask
   // The 1000BASE-X run spends two longer timer periods than the SGMII run.
   task automatic t_timer();
      restart();
      wait_done(n_sg);
      check("sgmii timer floor", {15'h0000, n_sg >= 2 * SG_CYC}, 16'h0001);
      sgmii_mode = 1'b0;
      restart();
      wait_done(n_bx);
      check("basex longer", {15'h0000, n_bx - n_sg >= 2 * (BX_CYC - SG_CYC) - 6}, 16'h0001);
      sgmii_mode = 1'b1;
   endtask
   task automatic t_disabled_and_sync();
      wr(SGAN_REG_IRQ_CTRL, 16'h0000);
      @(negedge mclk) sync_ok = 1'b0;
      repeat (3) @(negedge mclk);
      sync_ok = 1'b1;
      rd(SGAN_REG_STATUS);
      check("done after sync loss", {15'h0000, got[SGAN_BIT_DONE]}, 16'h0000);
      wait_done(n_sg);
      check("done after sync", {15'h0000, ok}, 16'h0001);
      check("irq stays low", {15'h0000, irq_hi | irq}, 16'h0000);
   endtask
   // A low clock enable freezes the unit mid-exchange; afterwards it still completes.
   task automatic t_freeze();
      logic [15:0] held;
      restart();
      repeat (30) @(negedge mclk);
      held = tx_word;
      ce = 1'b0;
      repeat (10) @(negedge mclk);
      check("frozen tx word", tx_word, held);
      ce = 1'b1;
      wait_done(n_sg);
      check("done after freeze", {15'h0000, ok}, 16'h0001);
   endtask
   // PHY mode forwards the MDIO result; corrections and buffer errors arrive meanwhile.
   task automatic t_phy_noise();
      int k;
      phy_mode = 1'b1;
      corr_en = 1'b1;
      noisy = 1'b1;
      restart();
      k = 0;
      while (!(tx_send && tx_word != 16'h0000) && k < 400) begin
         @(negedge mclk);
         k++;
      end
      check("forwarded ability", tx_word & 16'h1C00, mdio_ab & 16'h1C00);
      wait_done(n_sg);
      check("done despite noise", {15'h0000, ok}, 16'h0001);
      noisy = 1'b0;
   endtask
   // ==========================================================
   // Main sequence.
   initial begin
      fail_count = 0;
      n_checks = 0;
      cyc = 0;
      rst = 1'b1;
      sgmii_mode = 1'b1;
      phy_mode = 1'b0;
      corr_en = 1'b0;
      noisy = 1'b0;
      ce = 1'b1;
      sync_ok = 1'b1;
      mdio_ab = 16'h0401;
      ab = 16'h1801;
      req = '0;
      repeat (8) @(negedge mclk);
      rst = 1'b0;
      t_reset();
      t_irq_and_result();
      t_timer();
      t_disabled_and_sync();
      t_freeze();
      t_phy_noise();
      wrap_up();
   end
endmodule
